//--- design/amd_decoder.sv
// addressing-mode sequencer: operand fetch and effective address
// assumes: memory answers a read with mem_rvalid, one byte, in order
//
// What this block does
// - decodes seventeen addressing modes across seven groups
// - inherent instructions are one byte, no operand fetch
// - immediate: opcode then one byte used as the operand value
// - short direct: one address byte, reach 00 to FF
// - long direct: two-byte address word, full 64K reach
// - indexed address is unsigned sum of chosen index and offset
// - indexed without offset: no extra byte, index alone
// - short indexed: byte offset plus index without wrap, up to 1FE
// - long indexed: word offset plus index, full 64K
// - short indirect: byte pointer read from page zero
// - long indirect: word pointer read from page zero address
// - non-indexed short forms reach page zero only; short indexed forms reach up to 1FE
// - long forms use more bytes and cycles
// - read-modify-write instructions accept only short forms
// - mask op sets interrupt level 3, unmask op sets level 0
`timescale 1ns/100ps
module amd_decoder
	import amd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input amd_mode_t mode,
	input wire logic idx_sel_y,
	input wire logic [7:0] idx_x,
	input wire logic [7:0] idx_y,
	input wire logic rmw_op,
	input wire logic mask_interrupts_op,
	input wire logic unmask_interrupts_op,
	input wire logic mem_rvalid,
	input wire logic [7:0] mem_rdata,
	output logic mem_req,
	output logic [15:0] mem_addr,
	output logic [15:0] pc,
	output logic [15:0] eff_addr,
	output logic [7:0] imm_value,
	output logic is_imm,
	output logic done,
	output logic illegal,
	output logic busy,
	output logic [1:0] int_mask
);
	typedef enum logic [2:0] {
		AMD_S_IDLE,
		AMD_S_OPND,
		AMD_S_PTR,
		AMD_S_DONE
	} amd_state_t;

	amd_state_t state_r;
	amd_mode_t mode_r;
	logic [1:0] nbytes;
	logic ptr_fetch;
	logic ptr_word;
	logic indexed;
	logic short_form;
	logic [1:0] left_r;
	logic [1:0] total_r;
	logic [15:0] acc_r;
	logic [7:0] idx_r;
	logic [15:0] pc_r;
	logic [15:0] eff_addr_r;
	logic [7:0] imm_r;
	logic is_imm_r;
	logic done_r;
	logic illegal_r;
	logic req_r;
	logic [15:0] maddr_r;
	logic [1:0] imask_r;
	logic busy_r;

	amd_len_dec u_len
	(
		.mode(state_r == AMD_S_IDLE ? mode : mode_r),
		.addr_bytes(nbytes),
		.ptr_fetch(ptr_fetch),
		.ptr_word(ptr_word),
		.indexed(indexed),
		.short_form(short_form)
	);

	// unsigned index plus base, 16-bit result
	function automatic logic [15:0] idx_add(input logic [15:0] base, input logic [7:0] ix);
		idx_add = base + {8'h00, ix};
	endfunction : idx_add

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= AMD_S_IDLE;
			mode_r <= AMD_INH;
			left_r <= 2'd0;
			total_r <= 2'd0;
			acc_r <= AMD_EA_RESET;
			idx_r <= 8'h00;
			pc_r <= AMD_PC_RESET;
			eff_addr_r <= AMD_EA_RESET;
			imm_r <= 8'h00;
			is_imm_r <= 1'b0;
			done_r <= 1'b0;
			illegal_r <= 1'b0;
			req_r <= 1'b0;
			maddr_r <= AMD_EA_RESET;
			busy_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			unique case (state_r)
				AMD_S_IDLE:
				if (start)
				begin
					mode_r <= mode;
					idx_r <= idx_sel_y ? idx_y : idx_x;
					acc_r <= AMD_EA_RESET;
					is_imm_r <= (mode == AMD_IMM);
					// pc points at the opcode; step past it
					pc_r <= pc_r + 16'h0001;
					if (rmw_op && !short_form)
					begin
						illegal_r <= 1'b1;
						done_r <= 1'b1;
						eff_addr_r <= AMD_EA_RESET;
					end
					else if (nbytes == 2'd0)
					begin
						illegal_r <= 1'b0;
						done_r <= 1'b1;
						eff_addr_r <= indexed ? {AMD_PAGE0_HI, (idx_sel_y ? idx_y : idx_x)}
							: AMD_EA_RESET;
					end
					else
					begin
						illegal_r <= 1'b0;
						left_r <= nbytes;
						total_r <= nbytes;
						req_r <= 1'b1;
						maddr_r <= pc_r + 16'h0001;
						state_r <= AMD_S_OPND;
						busy_r <= 1'b1;
					end
				end
				AMD_S_OPND:
				if (mem_rvalid)
				begin
					acc_r <= {acc_r[7:0], mem_rdata};
					pc_r <= pc_r + 16'h0001;
					left_r <= left_r - 2'd1;
					if (left_r == 2'd1)
					begin
						if (ptr_fetch)
						begin
							// pointer lives in page zero
							maddr_r <= {AMD_PAGE0_HI, mem_rdata};
							left_r <= ptr_word ? 2'd2 : 2'd1;
							acc_r <= AMD_EA_RESET;
							state_r <= AMD_S_PTR;
						end
						else
						begin
							req_r <= 1'b0;
							state_r <= AMD_S_DONE;
						end
					end
					else
						maddr_r <= maddr_r + 16'h0001;
				end
				AMD_S_PTR:
				if (mem_rvalid)
				begin
					acc_r <= {acc_r[7:0], mem_rdata};
					left_r <= left_r - 2'd1;
					maddr_r <= maddr_r + 16'h0001;
					if (left_r == 2'd1)
					begin
						req_r <= 1'b0;
						state_r <= AMD_S_DONE;
					end
				end
				AMD_S_DONE:
				begin
					done_r <= 1'b1;
					state_r <= AMD_S_IDLE;
					busy_r <= 1'b0;
					if (is_imm_r)
					begin
						imm_r <= acc_r[7:0];
						eff_addr_r <= AMD_EA_RESET;
					end
					else if (indexed)
						eff_addr_r <= idx_add(acc_r, idx_r);
					else if (short_form)
						eff_addr_r <= {AMD_PAGE0_HI, acc_r[7:0]};
					else
						eff_addr_r <= acc_r;
				end
				default:
				begin
					state_r <= AMD_S_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// interrupt mask level
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			imask_r <= AMD_IMASK_RESET;
		else if (mask_interrupts_op)
			imask_r <= AMD_IMASK_SET;
		else if (unmask_interrupts_op)
			imask_r <= AMD_IMASK_CLR;
	end

	assign mem_req = req_r;
	assign mem_addr = maddr_r;
	assign pc = pc_r;
	assign eff_addr = eff_addr_r;
	assign imm_value = imm_r;
	assign is_imm = is_imm_r;
	assign done = done_r;
	assign illegal = illegal_r;
	assign busy = busy_r;
	assign int_mask = imask_r;
endmodule : amd_decoder

//--- design/amd_len_dec.sv
// operand byte count and attributes for one addressing mode
// assumes: mode comes from the same clock domain, purely combinational
`timescale 1ns/100ps
module amd_len_dec
	import amd_pkg::*;
(
	input amd_mode_t mode,
	output logic [1:0] addr_bytes,
	output logic ptr_fetch,
	output logic ptr_word,
	output logic indexed,
	output logic short_form
);
	always_comb
	begin
		addr_bytes = 2'd0;
		ptr_fetch = 1'b0;
		ptr_word = 1'b0;
		indexed = 1'b0;
		short_form = 1'b1;
		unique case (mode)
			AMD_INH: addr_bytes = 2'd0;
			AMD_IMM: addr_bytes = 2'd1;
			AMD_DIR_S: addr_bytes = 2'd1;
			AMD_DIR_L:
			begin
				addr_bytes = 2'd2;
				short_form = 1'b0;
			end
			AMD_IDX_0: indexed = 1'b1;
			AMD_IDX_S:
			begin
				addr_bytes = 2'd1;
				indexed = 1'b1;
			end
			AMD_IDX_L:
			begin
				addr_bytes = 2'd2;
				indexed = 1'b1;
				short_form = 1'b0;
			end
			AMD_IND_S:
			begin
				addr_bytes = 2'd1;
				ptr_fetch = 1'b1;
			end
			AMD_IND_L:
			begin
				addr_bytes = 2'd1;
				ptr_fetch = 1'b1;
				ptr_word = 1'b1;
				short_form = 1'b0;
			end
			AMD_IIX_S:
			begin
				addr_bytes = 2'd1;
				ptr_fetch = 1'b1;
				indexed = 1'b1;
			end
			AMD_IIX_L:
			begin
				addr_bytes = 2'd1;
				ptr_fetch = 1'b1;
				ptr_word = 1'b1;
				indexed = 1'b1;
				short_form = 1'b0;
			end
			AMD_REL_D: addr_bytes = 2'd1;
			AMD_REL_I:
			begin
				addr_bytes = 2'd1;
				ptr_fetch = 1'b1;
			end
			AMD_BIT_D: addr_bytes = 2'd1;
			AMD_BIT_I:
			begin
				addr_bytes = 2'd1;
				ptr_fetch = 1'b1;
			end
			AMD_BTJ_D: addr_bytes = 2'd1;
			AMD_BTJ_I:
			begin
				addr_bytes = 2'd1;
				ptr_fetch = 1'b1;
			end
			default: addr_bytes = 2'd0;
		endcase
	end
endmodule : amd_len_dec

//--- design/amd_pkg.sv
// constants and types for the addressing-mode decoder
// assumes: single clock, byte-wide program/data memory bus
package amd_pkg;
	// the seventeen addressing modes
	typedef enum logic [4:0] {
		AMD_INH,
		AMD_IMM,
		AMD_DIR_S,
		AMD_DIR_L,
		AMD_IDX_0,
		AMD_IDX_S,
		AMD_IDX_L,
		AMD_IND_S,
		AMD_IND_L,
		AMD_IIX_S,
		AMD_IIX_L,
		AMD_REL_D,
		AMD_REL_I,
		AMD_BIT_D,
		AMD_BIT_I,
		AMD_BTJ_D,
		AMD_BTJ_I
	} amd_mode_t;
	localparam int AMD_MODE_COUNT = 17;
	localparam logic [15:0] AMD_PC_RESET = 16'h0000;
	localparam logic [15:0] AMD_EA_RESET = 16'h0000;
	localparam logic [1:0] AMD_IMASK_RESET = 2'h3;
	localparam logic [1:0] AMD_IMASK_SET = 2'h3;
	localparam logic [1:0] AMD_IMASK_CLR = 2'h0;
	localparam logic [7:0] AMD_PAGE0_HI = 8'h00;
endpackage : amd_pkg

//--- test/amd_decoder_properties.sv
// port checker for the addressing-mode decoder
// assumes: bound into amd_decoder, single clock, rst active high
`timescale 1ns/100ps
module amd_decoder_properties
	import amd_pkg::*;
(
	input logic sys_clk,
	input logic rst,
	input logic start,
	input amd_mode_t mode,
	input logic rmw_op,
	input logic mask_interrupts_op,
	input logic unmask_interrupts_op,
	input logic mem_rvalid,
	input logic mem_req,
	input logic [15:0] mem_addr,
	input logic done,
	input logic illegal,
	input logic busy,
	input logic [1:0] int_mask
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence take_s;
		start && !busy;
	endsequence
	sequence rmw_long_s;
		take_s ##0 (rmw_op && mode == AMD_DIR_L);
	endsequence
	done_pulse_a: assert property (done && !(start && !busy) |=> !done)
		else $error("done longer than one cycle");
	done_bound_a: assert property (take_s |-> ##[1:40] done)
		else $error("decode never finished");
	rmw_refuse_a: assert property (rmw_long_s |=> done && illegal && !mem_req)
		else $error("long form accepted for rmw");
	inh_quick_a: assert property (take_s ##0 (mode == AMD_INH && !rmw_op) |=> done && !mem_req)
		else $error("inherent fetched bytes");
	idle_quiet_a: assert property (!busy |-> !mem_req)
		else $error("request while idle");
	req_hold_a: assert property (mem_req && !mem_rvalid |=> mem_req && $stable(mem_addr))
		else $error("request dropped early");
	mask_set_a: assert property (mask_interrupts_op |=> int_mask == AMD_IMASK_SET)
		else $error("mask level wrong");
	mask_clr_a: assert property (unmask_interrupts_op && !mask_interrupts_op |=> int_mask == AMD_IMASK_CLR)
		else $error("unmask level wrong");
endmodule : amd_decoder_properties

bind amd_decoder amd_decoder_properties amd_decoder_properties_i
(
	.sys_clk(sys_clk),
	.rst(rst),
	.start(start),
	.mode(mode),
	.rmw_op(rmw_op),
	.mask_interrupts_op(mask_interrupts_op),
	.unmask_interrupts_op(unmask_interrupts_op),
	.mem_rvalid(mem_rvalid),
	.mem_req(mem_req),
	.mem_addr(mem_addr),
	.done(done),
	.illegal(illegal),
	.busy(busy),
	.int_mask(int_mask)
);

//--- test/amd_mem_model.sv
// program and data memory answering one byte per request
// assumes: requester holds mem_req and mem_addr until mem_rvalid
`timescale 1ns/100ps
module amd_mem_model
(
	input logic sys_clk,
	input logic rst,
	input logic mem_req,
	input logic [15:0] mem_addr,
	input logic [1:0] lag,
	output logic mem_rvalid,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem_bytes [256];
	logic [1:0] wait_r;
	initial
	begin
		for (int k = 0; k < 256; k++) mem_bytes[k] = 8'(k) ^ 8'ha5;
	end
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			mem_rvalid <= 1'b0;
			mem_rdata <= 8'h00;
			wait_r <= 2'h0;
		end
		else
		begin
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_r <= mem_req ? wait_r + 2'h1 : 2'h0;
			if (mem_req && !mem_rvalid && wait_r >= lag)
			begin
				mem_rvalid <= 1'b1;
				mem_rdata <= mem_bytes[mem_addr[7:0] ^ mem_addr[15:8]];
				wait_r <= 2'h0;
			end
		end
	end
endmodule : amd_mem_model

//--- test/cpu_addressing_mode_decoder_test.sv
// self-checking bench for the addressing-mode decoder
// assumes: amd_mem_model stands in for the memory
`timescale 1ns/100ps
module cpu_addressing_mode_decoder_test
	import amd_pkg::*;
;
	logic sys_clk = 1'b0, rst = 1'b1, start = 1'b0, idx_sel_y = 1'b0, rmw_op = 1'b0;
	logic mask_interrupts_op = 1'b0, unmask_interrupts_op = 1'b0;
	logic mem_rvalid, mem_req, is_imm, done, illegal, busy;
	amd_mode_t mode = AMD_INH;
	logic [7:0] idx_x = 8'hff, idx_y = 8'h10, mem_rdata, imm_value;
	logic [15:0] mem_addr, pc, eff_addr, p, pa;
	logic [1:0] int_mask, lag = 2'h0;
	int miscompares = 0, num_checks = 0;
	amd_decoder amd_decoder_i
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.start(start),
		.mode(mode),
		.idx_sel_y(idx_sel_y),
		.idx_x(idx_x),
		.idx_y(idx_y),
		.rmw_op(rmw_op),
		.mask_interrupts_op(mask_interrupts_op),
		.unmask_interrupts_op(unmask_interrupts_op),
		.mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.pc(pc),
		.eff_addr(eff_addr),
		.imm_value(imm_value),
		.is_imm(is_imm),
		.done(done),
		.illegal(illegal),
		.busy(busy),
		.int_mask(int_mask)
	);
	amd_mem_model amd_mem_model_i
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.lag(lag),
		.mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata)
	);
	always #12.5 sys_clk = ~sys_clk;
	function automatic logic [7:0] rd(input logic [15:0] a);
		return amd_mem_model_i.mem_bytes[a[7:0] ^ a[15:8]];
	endfunction : rd
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		if (got !== exp)
			miscompares++;
	endtask : chk
	task automatic run(input amd_mode_t m, input logic [15:0] inc, input logic [15:0] ea);
		int n;
		p = pc;
		mode = m;
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
		for (n = 0; n < 60 && done !== 1'b1; n++) @(negedge sys_clk);
		chk({15'h0000, n < 60}, 16'h0001);
		chk(pc, p + 16'h0001 + inc);
		chk(eff_addr, ea);
		@(negedge sys_clk);
	endtask : run
	task automatic test_basic;
		run(AMD_INH, 16'h0000, 16'h0000);
		run(AMD_IMM, 16'h0001, 16'h0000);
		chk({8'h00, imm_value}, {8'h00, rd(p + 16'h0001)});
		chk({15'h0000, is_imm}, 16'h0001);
		run(AMD_DIR_S, 16'h0001, {8'h00, rd(pc + 16'h0001)});
		chk({15'h0000, is_imm}, 16'h0000);
		lag = 2'h3;
		run(AMD_DIR_L, 16'h0002, {rd(pc + 16'h0001), rd(pc + 16'h0002)});
		lag = 2'h0;
		$display("test basic done");
	endtask : test_basic
	task automatic test_indexed;
		idx_sel_y = 1'b1;
		run(AMD_IDX_0, 16'h0000, {8'h00, idx_y});
		idx_sel_y = 1'b0;
		pa = pc + 16'h0001;
		amd_mem_model_i.mem_bytes[pa[7:0] ^ pa[15:8]] = 8'hff;
		run(AMD_IDX_S, 16'h0001, 16'h01fe);
		run(AMD_IDX_L, 16'h0002, {rd(pc + 16'h0001), rd(pc + 16'h0002)} + 16'(idx_x));
		$display("test indexed done");
	endtask : test_indexed
	task automatic test_indirect;
		pa = {8'h00, rd(pc + 16'h0001)};
		run(AMD_IND_S, 16'h0001, {8'h00, rd(pa)});
		pa = {8'h00, rd(pc + 16'h0001)};
		run(AMD_IND_L, 16'h0001, {rd(pa), rd(pa + 16'h0001)});
		$display("test indirect done");
	endtask : test_indirect
	task automatic test_rmw;
		rmw_op = 1'b1;
		run(AMD_DIR_L, 16'h0000, 16'h0000);
		chk({15'h0000, illegal}, 16'h0001);
		run(AMD_DIR_S, 16'h0001, {8'h00, rd(pc + 16'h0001)});
		chk({15'h0000, illegal}, 16'h0000);
		rmw_op = 1'b0;
		pa = {8'h00, rd(pc + 16'h0001)};
		run(AMD_IIX_S, 16'h0001, {8'h00, rd(pa)} + 16'(idx_x));
		pa = {8'h00, rd(pc + 16'h0001)};
		run(AMD_IIX_L, 16'h0001, {rd(pa), rd(pa + 16'h0001)} + 16'(idx_x));
		run(AMD_REL_D, 16'h0001, {8'h00, rd(pc + 16'h0001)});
		pa = {8'h00, rd(pc + 16'h0001)};
		run(AMD_REL_I, 16'h0001, {8'h00, rd(pa)});
		run(AMD_BIT_D, 16'h0001, {8'h00, rd(pc + 16'h0001)});
		pa = {8'h00, rd(pc + 16'h0001)};
		run(AMD_BIT_I, 16'h0001, {8'h00, rd(pa)});
		run(AMD_BTJ_D, 16'h0001, {8'h00, rd(pc + 16'h0001)});
		pa = {8'h00, rd(pc + 16'h0001)};
		run(AMD_BTJ_I, 16'h0001, {8'h00, rd(pa)});
		$display("test rmw and other modes done");
	endtask : test_rmw
	task automatic test_mask;
		chk({14'h0000, int_mask}, {14'h0000, AMD_IMASK_RESET});
		unmask_interrupts_op = 1'b1;
		@(negedge sys_clk);
		unmask_interrupts_op = 1'b0;
		chk({14'h0000, int_mask}, {14'h0000, AMD_IMASK_CLR});
		mask_interrupts_op = 1'b1;
		unmask_interrupts_op = 1'b1;
		@(negedge sys_clk);
		mask_interrupts_op = 1'b0;
		unmask_interrupts_op = 1'b0;
		chk({14'h0000, int_mask}, {14'h0000, AMD_IMASK_SET});
		$display("test mask done");
	endtask : test_mask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial
	begin
		#50000;
		miscompares++;
		end_of_test;
	end
	initial
	begin
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		test_basic;
		test_indexed;
		test_indirect;
		test_rmw;
		test_mask;
		end_of_test;
	end
endmodule : cpu_addressing_mode_decoder_test
